// file: sfpi_core.sv
// Pin front end of the serial flash memory
//
// Contract
// RULE1 - Select high: deselected, standby, serial output released.
// RULE2 - Select high: serial input ignored entirely.
// RULE3 - Select falling starts an operation, select rising ends it.
// RULE4 - Select rising during self-timed cycle: finish cycle before standby.
// RULE5 - Serial input sampled on rising shift clock edges.
// RULE6 - Serial output updated on falling shift clock edges.
// RULE7 - Works with shift clock idling low or high.
// RULE8 - Eight-bit opcode first, then address bytes.
// RULE9 - All bytes most significant bit first both ways.
// RULE10 - Write-protect low blocks program/erase on mapped sectors.
// RULE11 - Write-protect low freezes the protection map; the protect command still sets its sector's map bit.
// RULE12 - Program/erase under write-protect dropped; idle at next deselect.
// RULE13 - Protection-enable and lock commands still work under write-protect.
// RULE14 - Write-protect defaults high via pull-up.
// RULE15 - Reset low aborts operation, control machine to idle.
// RULE16 - Held in reset while reset low, resumes when high.
// RULE17 - Internal power-on reset, no reset pin sequence needed.
// RULE18 - Host should drive reset high when unused.
// RULE19 - Program and erase cycles timed internally.
// RULE20 - Page size 528 by default, 512 selectable.
// RULE21 - Two page-long buffers; one loads while array programs. Code toggles activeBuffer but ignores select falling while busy.
// RULE22 - Select falling clears the serial bit counter.
`include "sfpi_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sfpi_core #(
   parameter int PROG_CYCLES = `SFPI_PROG_CYCLES,
   parameter int SECTORS = `SFPI_SECTORS,
   parameter logic BINARY_PAGE_DEFAULT = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial pins
   input wire logic selectN,
   input wire logic shiftClk,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutEn,
   // Control pins
   input wire logic writeProtectN,
   input wire logic resetN,
   // Decoded command classes for the first received byte
   input wire sfpi_pkg::sfpi_cmd_type cmdClass,
   input wire logic [7:0] addrBytes,
   input wire logic [$clog2(SECTORS)-1:0] cmdSector,
   input wire logic [SECTORS-1:0] mapWriteValue,
   input wire logic pageSizeBinarySet,
   // Read data for shifting out
   input wire logic [7:0] readByte,
   // Received byte stream
   output sfpi_pkg::sfpi_byte_type rxByte,
   output logic readByteTake,
   // Status
   output logic busy,
   output logic programStart,
   output logic programDropped,
   output logic [SECTORS-1:0] protectMap,
   output logic protectEnabled,
   output logic binaryPage,
   output logic activeBuffer
);
   localparam int PROG_W = $clog2(PROG_CYCLES + 1);
   localparam int POR_W = $clog2(`SFPI_POR_CYCLES + 1);

   logic [2:0] pinSync;
   logic selN;
   logic sclk;
   logic sin;
   logic sclkPrev;
   logic selPrev;
   logic wpN;
   logic rstPin;
   logic [POR_W-1:0] porCount;
   logic intRst;
   sfpi_pkg::sfpi_state_type state;
   logic [2:0] bitCount;
   logic [7:0] shiftIn;
   logic [7:0] shiftOut;
   logic [7:0] addrCount;
   sfpi_pkg::sfpi_cmd_type opClass;
   logic [PROG_W-1:0] progCount;
   logic riseEdge;
   logic fallEdge;
   logic selFall;
   logic selRise;
   logic byteDone;
   logic progGo;
   logic progDrop;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   sfpi_sync #(.WIDTH(3), .INIT(3'b001)) u_syncSer (
      .clk(clk),
      .nrst(nrst),
      .pinIn({serialIn, shiftClk, selectN}),
      .syncOut(pinSync)
   );
   // Write-protect and reset pins idle high as if pulled up
   sfpi_sync #(.WIDTH(2), .INIT(2'b11)) u_syncCtl (
      .clk(clk),
      .nrst(nrst),
      .pinIn({writeProtectN, resetN}), // RULE14
      .syncOut({wpN, rstPin})
   );
   assign selN = pinSync[0];
   assign sclk = pinSync[1];
   assign sin = pinSync[2];

   // ----------------------------------------
   // Power-on and pin reset
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         porCount <= '0; // RULE17
      end else if (porCount != POR_W'(`SFPI_POR_CYCLES)) begin
         porCount <= porCount + POR_W'(1);
      end
   end
   // Held while the pin is low, released when it returns high
   assign intRst = !nrst || (porCount != POR_W'(`SFPI_POR_CYCLES)) || !rstPin; // RULE15 RULE16

   // ----------------------------------------
   // Edge detection
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sclkPrev <= 1'b0;
         selPrev <= 1'b1;
      end else begin
         sclkPrev <= sclk;
         selPrev <= selN;
      end
   end
   // Edges counted only while selected, so either idle level works
   assign riseEdge = !selN && sclk && !sclkPrev; // RULE5 RULE7 RULE2
   assign fallEdge = !selN && !sclk && sclkPrev; // RULE6 RULE7
   assign selFall = selPrev && !selN; // RULE3
   assign selRise = !selPrev && selN; // RULE3
   assign byteDone = riseEdge && (bitCount == 3'd7);
   function automatic logic is_program(input sfpi_pkg::sfpi_cmd_type cls);
      return cls == sfpi_pkg::SFPI_CMD_PROGRAM;
   endfunction
   // Program goes ahead on an unguarded sector, dropped under write-protect
   assign progGo = is_program(opClass) &&
                   !(protectMap[cmdSector] && (!wpN || protectEnabled)); // RULE10
   assign progDrop = is_program(cmdClass) && !wpN; // RULE12

   // ----------------------------------------
   // Shift in
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (intRst) begin
         bitCount <= '0;
         shiftIn <= '0;
      end else if (selFall) begin
         bitCount <= '0; // RULE22
      end else if (riseEdge) begin
         shiftIn <= {shiftIn[6:0], sin}; // RULE9
         bitCount <= bitCount + 3'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (intRst) begin
         rxByte <= '0;
      end else begin
         rxByte.valid <= byteDone;
         rxByte.data <= {shiftIn[6:0], sin};
         rxByte.first <= byteDone && (state == sfpi_pkg::SFPI_OPCODE); // RULE8
      end
   end

   // ----------------------------------------
   // Shift out
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (intRst) begin
         shiftOut <= '0;
         serialOut <= 1'b0;
         readByteTake <= 1'b0;
      end else begin
         readByteTake <= fallEdge && (bitCount == 3'd0);
         if (fallEdge) begin
            if (bitCount == 3'd0) begin
               serialOut <= readByte[7]; // RULE6 RULE9
               shiftOut <= {readByte[6:0], 1'b0};
            end else begin
               serialOut <= shiftOut[7]; // RULE6
               shiftOut <= {shiftOut[6:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (intRst) begin
         serialOutEn <= 1'b0;
      end else begin
         serialOutEn <= !selN && (state == sfpi_pkg::SFPI_DATA); // RULE1
      end
   end

   // ----------------------------------------
   // Control state machine
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (intRst) begin
         state <= sfpi_pkg::SFPI_IDLE; // RULE15
         opClass <= sfpi_pkg::SFPI_CMD_OTHER;
         addrCount <= '0;
      end else begin
         unique case (state)
            sfpi_pkg::SFPI_IDLE: begin
               if (selFall) begin
                  state <= sfpi_pkg::SFPI_OPCODE; // RULE3
               end
            end
            sfpi_pkg::SFPI_OPCODE: begin
               if (selN) begin
                  state <= sfpi_pkg::SFPI_IDLE;
               end else if (byteDone) begin
                  opClass <= cmdClass;
                  addrCount <= addrBytes;
                  if (progDrop) begin
                     state <= sfpi_pkg::SFPI_DROP; // RULE12
                  end else if (addrBytes == 8'd0) begin
                     state <= sfpi_pkg::SFPI_DATA;
                  end else begin
                     state <= sfpi_pkg::SFPI_ADDR; // RULE8
                  end
               end
            end
            sfpi_pkg::SFPI_ADDR: begin
               if (selN) begin
                  state <= sfpi_pkg::SFPI_IDLE;
               end else if (byteDone) begin
                  addrCount <= addrCount - 8'd1;
                  if (addrCount == 8'd1) begin
                     state <= sfpi_pkg::SFPI_DATA;
                  end
               end
            end
            sfpi_pkg::SFPI_DATA: begin
               if (selRise) begin
                  if (progGo) begin
                     state <= sfpi_pkg::SFPI_BUSY; // RULE4 RULE10
                  end else begin
                     state <= sfpi_pkg::SFPI_IDLE;
                  end
               end
            end
            sfpi_pkg::SFPI_DROP: begin
               if (selN) begin
                  state <= sfpi_pkg::SFPI_IDLE; // RULE12
               end
            end
            sfpi_pkg::SFPI_BUSY: begin
               if (progCount == PROG_W'(1)) begin
                  state <= sfpi_pkg::SFPI_IDLE; // RULE4 RULE19
               end
            end
            default: begin
               state <= sfpi_pkg::SFPI_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Self-timed program cycle
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (intRst) begin
         progCount <= '0;
         programStart <= 1'b0;
         programDropped <= 1'b0;
         busy <= 1'b0;
      end else begin
         programStart <= 1'b0;
         programDropped <= (state == sfpi_pkg::SFPI_OPCODE) && byteDone && progDrop;
         if ((state == sfpi_pkg::SFPI_DATA) && selRise && progGo) begin
            progCount <= PROG_W'(PROG_CYCLES); // RULE19
            programStart <= 1'b1;
         end else if (progCount != '0) begin
            progCount <= progCount - PROG_W'(1);
         end
         busy <= (state == sfpi_pkg::SFPI_BUSY && progCount > PROG_W'(1)) ||
                 (programStart);
      end
   end

   // ----------------------------------------
   // Protection, page size and buffers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (intRst) begin
         protectMap <= '0;
         protectEnabled <= 1'b0;
         binaryPage <= BINARY_PAGE_DEFAULT; // RULE20
         activeBuffer <= 1'b0;
      end else if (state == sfpi_pkg::SFPI_DATA && selRise) begin
         unique case (opClass)
            sfpi_pkg::SFPI_CMD_PROTECT: begin
               protectEnabled <= 1'b1; // RULE13
               protectMap[cmdSector] <= 1'b1;
            end
            sfpi_pkg::SFPI_CMD_MAPWRITE: begin
               if (wpN) begin
                  protectMap <= mapWriteValue; // RULE11
               end
            end
            sfpi_pkg::SFPI_CMD_PROGRAM: begin
               activeBuffer <= !activeBuffer; // RULE21
            end
            sfpi_pkg::SFPI_CMD_OTHER: begin
               if (pageSizeBinarySet) begin
                  binaryPage <= 1'b1; // RULE20
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: sfpi_regs.svh
// Constants of the serial flash pin interface
`ifndef SFPI_REGS_SVH
`define SFPI_REGS_SVH
`define SFPI_OPCODE_BITS 8
`define SFPI_PAGE_DEFAULT 528
`define SFPI_PAGE_BINARY 512
`define SFPI_PROG_TIME_US 3000
`define SFPI_CLK_MHZ 200
`define SFPI_PROG_CYCLES (`SFPI_PROG_TIME_US * `SFPI_CLK_MHZ)
`define SFPI_POR_CYCLES 16
`define SFPI_SECTORS 16
`endif

// file: sfpi_pkg.sv
// Types of the serial flash pin interface
`default_nettype none
package sfpi_pkg;
   typedef enum logic [2:0] {
      SFPI_IDLE = 3'b000,
      SFPI_OPCODE = 3'b001,
      SFPI_ADDR = 3'b010,
      SFPI_DATA = 3'b011,
      SFPI_DROP = 3'b100,
      SFPI_BUSY = 3'b101
   } sfpi_state_type;

   typedef enum logic [1:0] {
      SFPI_CMD_OTHER = 2'b00,
      SFPI_CMD_PROGRAM = 2'b01,
      SFPI_CMD_PROTECT = 2'b10,
      SFPI_CMD_MAPWRITE = 2'b11
   } sfpi_cmd_type;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic first;
   } sfpi_byte_type;
endpackage
`default_nettype wire

// file: sfpi_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfpi_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pins
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         stage1 <= INIT;
         syncOut <= INIT;
      end else begin
         stage1 <= pinIn;
         syncOut <= stage1;
      end
   end
endmodule
`default_nettype wire

// file: sfpi_core_checker.sv
// Assertion checker for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module sfpi_core_checker #(
   parameter int PROG_CYCLES = 50,
   parameter int SECTORS = 16,
   parameter logic BINARY_PAGE_DEFAULT = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pins
   input wire logic selectN,
   input wire logic writeProtectN,
   input wire logic resetN,
   input wire logic serialOutEn,
   // Status
   input wire sfpi_pkg::sfpi_byte_type rxByte,
   input wire logic busy,
   input wire logic programStart,
   input wire logic programDropped,
   input wire logic [SECTORS-1:0] protectMap,
   input wire logic binaryPage
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence deselected;
      selectN [*6];
   endsequence
   sequence guarded;
      !writeProtectN [*6];
   endsequence
   a_out_released: assert property (deselected |-> !serialOutEn)
      else $error("output enabled while deselected");
   a_rx_ignored: assert property (deselected |-> !rxByte.valid)
      else $error("byte received while deselected");
   a_busy_holds: assert property (programStart |-> ##[0:2] busy [*8])
      else $error("busy missing after program start");
   a_drop_quiet: assert property (programDropped |-> (!busy && !programStart) [*8])
      else $error("dropped program still started");
   a_wp_no_start: assert property (guarded |-> !programStart)
      else $error("program started under write protect");
   a_map_frozen: assert property (guarded |=> $stable(protectMap))
      else $error("protection map changed under write protect");
   a_reset_idle: assert property (!resetN [*5] |-> !busy && !serialOutEn && !rxByte.valid)
      else $error("activity while reset pin low");
   a_page_default: assert property ($rose(nrst) |-> (binaryPage == BINARY_PAGE_DEFAULT) [*8])
      else $error("page size not at default after reset");
endmodule
bind sfpi_core sfpi_core_checker #(
   .PROG_CYCLES(PROG_CYCLES), .SECTORS(SECTORS), .BINARY_PAGE_DEFAULT(BINARY_PAGE_DEFAULT)
) chk (
   .clk(clk), .nrst(nrst), .selectN(selectN), .writeProtectN(writeProtectN), .resetN(resetN),
   .serialOutEn(serialOutEn), .rxByte(rxByte), .busy(busy), .programStart(programStart),
   .programDropped(programDropped), .protectMap(protectMap), .binaryPage(binaryPage)
);
`default_nettype wire

// file: sfpi_host.sv
// Host controller model driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module sfpi_host (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic selectN,
   output logic shiftClk,
   output logic serialIn,
   input wire logic serialOut
);
   logic inFrame = 1'b0;
   initial begin
      selectN = 1'b1;
      shiftClk = 1'b0;
      serialIn = 1'b0;
   end
   // Data line wanders between frames
   always @(negedge clk) begin
      if (!inFrame) begin
         serialIn <= ~serialIn;
      end
   end
   task automatic wait_half();
      repeat (8) @(negedge clk);
   endtask
   task automatic start(input logic mode3);
      // Shared bus clock runs while this device is deselected
      repeat (16) begin
         shiftClk = ~shiftClk;
         wait_half();
      end
      inFrame = 1'b1;
      shiftClk = mode3;
      wait_half();
      selectN = 1'b0;
      wait_half();
   endtask
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         shiftClk = 1'b0;
         serialIn = tx[i];
         wait_half();
         rx[i] = serialOut;
         shiftClk = 1'b1;
         wait_half();
      end
   endtask
   task automatic stop(input logic mode3);
      shiftClk = mode3;
      wait_half();
      selectN = 1'b1;
      inFrame = 1'b0;
      wait_half();
   endtask
endmodule
`default_nettype wire

// file: sfpi_core_test.sv
// Self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module sfpi_core_test;
   localparam int PROG = 50;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic writeProtectN = 1'b1;
   logic resetN = 1'b1;
   sfpi_pkg::sfpi_cmd_type cmdClass = sfpi_pkg::SFPI_CMD_OTHER;
   logic [7:0] addrBytes = 8'h00;
   logic [3:0] cmdSector = 4'h0;
   logic [15:0] mapWriteValue = 16'h0000;
   logic pageSizeBinarySet = 1'b0;
   logic [7:0] readByte = 8'h00;
   logic selectN, shiftClk, serialIn, serialOut, serialOutEn, busy, programStart;
   logic programDropped, protectEnabled, binaryPage, activeBuffer, readByteTake;
   logic [15:0] protectMap;
   sfpi_pkg::sfpi_byte_type rxByte;
   wire logic soPin;
   int errors = 0;
   int compares = 0;
   int starts = 0;
   int drops = 0;
   int takes = 0;
   logic [31:0] seed = 32'ha239;
   logic [8:0] rxq[$];
   assign soPin = serialOutEn ? serialOut : 1'bz;
   sfpi_core #(.PROG_CYCLES(PROG), .SECTORS(16)) dut (
      .clk(clk), .nrst(nrst), .selectN(selectN), .shiftClk(shiftClk), .serialIn(serialIn),
      .serialOut(serialOut), .serialOutEn(serialOutEn), .writeProtectN(writeProtectN),
      .resetN(resetN), .cmdClass(cmdClass), .addrBytes(addrBytes), .cmdSector(cmdSector),
      .mapWriteValue(mapWriteValue), .pageSizeBinarySet(pageSizeBinarySet),
      .readByte(readByte), .rxByte(rxByte), .readByteTake(readByteTake), .busy(busy),
      .programStart(programStart), .programDropped(programDropped), .protectMap(protectMap),
      .protectEnabled(protectEnabled), .binaryPage(binaryPage), .activeBuffer(activeBuffer)
   );
   sfpi_host host (
      .clk(clk), .selectN(selectN), .shiftClk(shiftClk), .serialIn(serialIn), .serialOut(soPin)
   );
   initial begin
      forever #2.5 clk = ~clk;
   end
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic frame(input logic mode3, input int nAddr, input int nData, output logic [7:0] rd);
      logic [7:0] tx;
      tx = 8'(rnd());
      addrBytes = 8'(nAddr);
      host.start(mode3);
      rxq.push_back({tx, 1'b1});
      host.xfer(tx, 8, rd);
      for (int i = 0; i < nAddr + nData; i++) begin
         tx = 8'(rnd());
         rxq.push_back({tx, 1'b0});
         host.xfer(tx, 8, rd);
      end
      host.stop(mode3);
   endtask
   // Received bytes against the oldest note
   always @(posedge clk) begin
      if (rxByte.valid === 1'b1) begin
         if (rxq.size() == 0) begin
            check("stray byte", 16'h1, 16'h0);
         end else begin
            check("rx byte", {7'h0, rxByte.data, rxByte.first}, {7'h0, rxq.pop_front()});
         end
      end
      if (programStart === 1'b1) starts++;
      if (programDropped === 1'b1) drops++;
      if (readByteTake === 1'b1) takes++;
   end
   initial begin
      #400000;
      errors++;
      wrap_up();
   end
   initial begin
      logic [7:0] rd;
      logic [15:0] map;
      logic buf0;
      int n;
      int s0;
      int d0;
      int t0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (30) @(negedge clk);
      host.start(1'b0);
      host.xfer(8'hff, 3, rd);
      host.stop(1'b0);
      for (int i = 0; i < 4; i++) begin
         readByte = 8'(rnd());
         t0 = takes;
         frame(i[0], i, 1, rd);
         check("read byte", {8'h0, rd}, {8'h0, readByte});
         check("out enable", 16'(serialOutEn), 16'h0);
         check("byte takes", 16'(takes - t0), 16'(i + 2));
      end
      $display("test reads done");
      check("page default", 16'(binaryPage), 16'h0);
      pageSizeBinarySet = 1'b1;
      frame(1'b0, 0, 0, rd);
      pageSizeBinarySet = 1'b0;
      check("page size", 16'(binaryPage), 16'h1);
      cmdClass = sfpi_pkg::SFPI_CMD_PROGRAM;
      cmdSector = 4'h3;
      buf0 = activeBuffer;
      s0 = starts;
      frame(1'b0, 3, 2, rd);
      n = 0;
      while (busy === 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      check("busy span", 16'(n > 0 && n < PROG), 16'h1);
      check("starts", 16'(starts - s0), 16'h1);
      check("buffer", 16'(activeBuffer), {15'h0, ~buf0});
      frame(1'b1, 3, 1, rd);
      repeat (4) @(negedge clk);
      resetN = 1'b0;
      repeat (8) @(negedge clk);
      check("busy in reset", 16'(busy), 16'h0);
      resetN = 1'b1;
      repeat (30) @(negedge clk);
      $display("test program done");
      map = rnd() | 16'h0008;
      mapWriteValue = map;
      cmdClass = sfpi_pkg::SFPI_CMD_MAPWRITE;
      frame(1'b1, 0, 0, rd);
      check("map", protectMap, map);
      writeProtectN = 1'b0;
      repeat (8) @(negedge clk);
      cmdClass = sfpi_pkg::SFPI_CMD_PROGRAM;
      s0 = starts;
      d0 = drops;
      frame(1'b0, 0, 0, rd);
      check("dropped", 16'(drops - d0), 16'h1);
      check("no start", 16'(starts - s0), 16'h0);
      mapWriteValue = ~map;
      cmdClass = sfpi_pkg::SFPI_CMD_MAPWRITE;
      frame(1'b1, 0, 0, rd);
      check("map frozen", protectMap, map);
      cmdClass = sfpi_pkg::SFPI_CMD_PROTECT;
      frame(1'b0, 0, 0, rd);
      check("enabled", 16'(protectEnabled), 16'h1);
      writeProtectN = 1'b1;
      repeat (8) @(negedge clk);
      cmdClass = sfpi_pkg::SFPI_CMD_PROGRAM;
      s0 = starts;
      frame(1'b1, 0, 0, rd);
      check("protected sector", 16'(starts - s0), 16'h0);
      check("queue left", 16'(rxq.size()), 16'h0);
      $display("test protect done");
      wrap_up();
   end
endmodule
`default_nettype wire
